// [inc/bridge_pkg.sv]
// Package with register map, field layout and timing constants for the bridge gate command logic
package bridge_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned DT_STEP_NS = 50;
    localparam int unsigned DT_MIN_NS = 100;
    localparam int unsigned DT_WIDTH = 6;
    localparam int unsigned DT_MIN_CODE = DT_MIN_NS / DT_STEP_NS;
    localparam int unsigned STEPS_PER_CLK = CLK_PERIOD_NS / DT_STEP_NS;
    localparam int unsigned CNT_WIDTH = 8;
    localparam logic [11:0] ADDR_CONTROL = 12'h000;
    localparam logic [11:0] ADDR_DEADTIME = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam int unsigned CTRL_AH = 0;
    localparam int unsigned CTRL_AL = 1;
    localparam int unsigned CTRL_BH = 2;
    localparam int unsigned CTRL_BL = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [5:0] DT_RESET = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic high;
        logic low;
    } gate_pair_t;
endpackage : bridge_pkg

// [logic/phase_dead_timer.sv]
// One half-bridge phase: lockout, dead-time insertion and top-off pump enable
`timescale 1ns/10ps
`default_nettype none
module phase_dead_timer #(
    parameter int unsigned CW = bridge_pkg::CNT_WIDTH
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic highReq,
    input wire logic lowReq,
    input wire logic [CW-1:0] gapCycles,
    output var bridge_pkg::gate_pair_t gate,
    output logic pumpOn
);
    logic [CW-1:0] gapLeft;
    logic bothReq;
    logic gapDone;
    logic noGap;
    logic next_high;
    logic next_low;

    assign bothReq = highReq && lowReq;
    assign gapDone = (gapLeft == '0);
    // Zero dead time lets one side hand over to the other on the same edge
    assign noGap = (gapCycles == '0);

    always_comb begin
        next_high = highReq && !bothReq && (!gate.low || noGap) && gapDone;
        next_low = lowReq && !bothReq && (!gate.high || noGap) && gapDone;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gate <= '0;
        end else if (clkEn) begin
            gate.high <= next_high;
            gate.low <= next_low;
        end
    end

    // Gap starts when either switch turns off; zero gap disables it
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gapLeft <= '0;
        end else if (clkEn) begin
            if ((gate.high && !next_high) || (gate.low && !next_low)) begin
                // Turn-off edge itself is the first gap cycle
                gapLeft <= noGap ? '0 : gapCycles - 1'b1;
            end else if (!gapDone) begin
                gapLeft <= gapLeft - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            pumpOn <= 1'b0;
        end else if (clkEn) begin
            pumpOn <= gate.high;
        end
    end

    a_no_shoot_through: assert property (@(posedge sys_clk) disable iff (!nrst) !(gate.high && gate.low))
        else $error("both gates of a phase on");
    a_both_forces_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clkEn && bothReq) |=> (!gate.high && !gate.low))
        else $error("both requested but a gate stayed on");
    a_pump_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clkEn && !gate.high) |=> !pumpOn)
        else $error("pump running without high-side on");
    a_gap_respected: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clkEn && !gapDone) |=> !($rose(gate.high) || $rose(gate.low)))
        else $error("turn-on during dead time");
endmodule : phase_dead_timer
`default_nettype wire

// [logic/bridge_gate_ctrl.sv]
// Top: AXI4-Lite registers, input polarity, request merge, enable gating for two phases
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - The top-off pump of a phase follows its high-side drive one clock later, on the cycle after the drive is on.
// - A gate command of 1 turns the switch on and 0 turns it off.
// - Dead time is the six-bit field times 50 ns, counted on the system clock.
// - Field values 1 and 2 both give 100 ns, and the top is 3.2 us.
// - A zero field gives no gap but keeps the lockout.
// - A turn-on is delayed only within one dead time of either gate of the phase turning off.
// - Phase A high and phase B low inputs are active high, the other two active low.
// - Each gate has one active-high control register bit.
// - Each request is the corrected input ORed with its register bit.
// - A disconnected input reads inactive.
// - Both gates of a phase never turn on together; a double request turns both off.
// - Phases run independently while sharing one dead-time setting.
// - The enable input gates outputs directly, past the phase logic.
module bridge_gate_ctrl #(
    parameter int unsigned DTW = bridge_pkg::DT_WIDTH
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clkEn,
    input wire logic phase_a_high_request,
    input wire logic phase_a_low_request_neg,
    input wire logic phase_b_high_request_neg,
    input wire logic phase_b_low_request,
    input wire logic outputEnable,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [1:0] high_side_gate_out,
    output logic [1:0] low_side_gate_out,
    output logic [1:0] topOffPumpOn
);
    logic [3:0] ctrlBits;
    logic [DTW-1:0] dead_time_count;
    logic [11:0] awAddr;
    logic awHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic wHeld;
    logic [3:0] pinReq;
    logic [3:0] gateReq;
    logic [DTW-1:0] dtEff;
    logic [bridge_pkg::CNT_WIDTH-1:0] gapCycles;
    bridge_pkg::gate_pair_t phaseGate [2];
    logic [1:0] pumpRaw;
    logic [3:0] statusBits;

    // Write channel: address and data captured in either order
    assign s_axi_awready = clkEn && !awHeld && !s_axi_bvalid;
    assign s_axi_wready = clkEn && !wHeld && !s_axi_bvalid;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            awHeld <= 1'b0;
            awAddr <= 12'h000;
        end else if (clkEn) begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end else if (awHeld && wHeld) begin
                awHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            wHeld <= 1'b0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
        end else if (clkEn) begin
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end else if (awHeld && wHeld) begin
                wHeld <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bridge_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (awHeld && wHeld) begin
                s_axi_bvalid <= 1'b1;
                if (awAddr == bridge_pkg::ADDR_CONTROL || awAddr == bridge_pkg::ADDR_DEADTIME) begin
                    s_axi_bresp <= bridge_pkg::RESP_OKAY;
                end else begin
                    s_axi_bresp <= bridge_pkg::RESP_SLVERR;
                end
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes on the cycle both halves are held
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ctrlBits <= bridge_pkg::CTRL_RESET;
            dead_time_count <= bridge_pkg::DT_RESET;
        end else if (clkEn && awHeld && wHeld && wStrb[0]) begin
            if (awAddr == bridge_pkg::ADDR_CONTROL) begin
                ctrlBits <= wData[3:0];
            end
            if (awAddr == bridge_pkg::ADDR_DEADTIME) begin
                dead_time_count <= wData[DTW-1:0];
            end
        end
    end

    // Read channel
    assign s_axi_arready = clkEn && !s_axi_rvalid;
    assign statusBits = {low_side_gate_out[1], high_side_gate_out[1], low_side_gate_out[0], high_side_gate_out[0]};

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= bridge_pkg::RESP_OKAY;
        end else if (clkEn) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= bridge_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    bridge_pkg::ADDR_CONTROL: s_axi_rdata <= {28'h000_0000, ctrlBits};
                    bridge_pkg::ADDR_DEADTIME: s_axi_rdata <= {26'h000_0000, dead_time_count};
                    bridge_pkg::ADDR_STATUS: s_axi_rdata <= {26'h000_0000, topOffPumpOn, statusBits};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= bridge_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Polarity correction; pins float to inactive outside this block
    assign pinReq[bridge_pkg::CTRL_AH] = phase_a_high_request;
    assign pinReq[bridge_pkg::CTRL_AL] = !phase_a_low_request_neg;
    assign pinReq[bridge_pkg::CTRL_BH] = !phase_b_high_request_neg;
    assign pinReq[bridge_pkg::CTRL_BL] = phase_b_low_request;
    assign gateReq = pinReq | ctrlBits;

    // Codes 1 and 2 share the 100 ns floor; 50 ns steps round up to whole clocks
    always_comb begin
        dtEff = dead_time_count;
        if (dead_time_count != '0 && dead_time_count < DTW'(bridge_pkg::DT_MIN_CODE)) begin
            dtEff = DTW'(bridge_pkg::DT_MIN_CODE);
        end
        gapCycles = (bridge_pkg::CNT_WIDTH'(dtEff) + bridge_pkg::CNT_WIDTH'(bridge_pkg::STEPS_PER_CLK - 1))
            / bridge_pkg::CNT_WIDTH'(bridge_pkg::STEPS_PER_CLK);
    end

    genvar ph;
    generate
        for (ph = 0; ph < 2; ph++) begin : g_phase
            phase_dead_timer #(
                .CW(bridge_pkg::CNT_WIDTH)
            ) u_phase (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .clkEn(clkEn),
                .highReq(gateReq[2*ph]),
                .lowReq(gateReq[2*ph+1]),
                .gapCycles(gapCycles),
                .gate(phaseGate[ph]),
                .pumpOn(pumpRaw[ph])
            );
            assign high_side_gate_out[ph] = phaseGate[ph].high && outputEnable;
            assign low_side_gate_out[ph] = phaseGate[ph].low && outputEnable;
            assign topOffPumpOn[ph] = pumpRaw[ph] && outputEnable;
        end
    endgenerate

    a_enable_cuts: assert property (@(posedge sys_clk) disable iff (!nrst)
        !outputEnable |-> (high_side_gate_out == 2'b00 && low_side_gate_out == 2'b00))
        else $error("gate on while disabled");
    a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clkEn && awHeld && wHeld && wStrb[0] && awAddr == bridge_pkg::ADDR_CONTROL)
        |=> ctrlBits == $past(wData[3:0]))
        else $error("control bits not written");
    a_dt_floor: assert property (@(posedge sys_clk) disable iff (!nrst)
        (dead_time_count == 6'h01 || dead_time_count == 6'h02) |-> gapCycles == 8'h01)
        else $error("short dead time not raised to floor");
    a_dt_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
        dead_time_count == 6'h00 |-> gapCycles == 8'h00)
        else $error("zero dead time still gaps");
    a_dt_top: assert property (@(posedge sys_clk) disable iff (!nrst)
        dead_time_count == 6'h3f |-> gapCycles == 8'h20)
        else $error("dead time scaling wrong");
    a_or_merge: assert property (@(posedge sys_clk) disable iff (!nrst)
        gateReq[0] == (phase_a_high_request || ctrlBits[0]))
        else $error("request merge wrong");
endmodule : bridge_gate_ctrl
`default_nettype wire

// [test/pwm_source.sv]
// Controller model driving the four direct phase request pins
`timescale 1ns/10ps
`default_nettype none
module pwm_source (
    input wire logic sys_clk,
    input wire logic [3:0] cmd,
    output logic phase_a_high_request,
    output logic phase_a_low_request_neg,
    output logic phase_b_high_request_neg,
    output logic phase_b_low_request
);
    // Pins idle at their inactive levels
    initial begin
        phase_a_high_request = 1'b0;
        phase_a_low_request_neg = 1'b1;
        phase_b_high_request_neg = 1'b1;
        phase_b_low_request = 1'b0;
    end
    // Command bits are active high; pins take their own polarity
    always @(posedge sys_clk) begin
        phase_a_high_request <= cmd[0];
        phase_a_low_request_neg <= ~cmd[1];
        phase_b_high_request_neg <= ~cmd[2];
        phase_b_low_request <= cmd[3];
    end
endmodule : pwm_source
`default_nettype wire

// [test/tb_bridge_gate_ctrl.sv]
// Testbench for the bridge gate command logic
`timescale 1ns/10ps
`default_nettype none
module tb_bridge_gate_ctrl;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic outputEnable = 1'b1;
    logic [3:0] cmd = 4'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pAH, pALn, pBHn, pBL;
    logic [1:0] bresp, rresp, highGate, lowGate, pump;
    logic [31:0] rdata;
    logic [3:0] gates;
    int nErrors = 0;
    int samplesChecked = 0;
    int codes [6] = '{0, 1, 2, 3, 48, 63};
    assign gates = {lowGate[1], highGate[1], lowGate[0], highGate[0]};
    always #50 sys_clk = ~sys_clk;
    pwm_source u_pwm_source (.sys_clk(sys_clk), .cmd(cmd), .phase_a_high_request(pAH),
        .phase_a_low_request_neg(pALn), .phase_b_high_request_neg(pBHn), .phase_b_low_request(pBL));
    bridge_gate_ctrl u_bridge_gate_ctrl (.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1),
        .phase_a_high_request(pAH), .phase_a_low_request_neg(pALn), .phase_b_high_request_neg(pBHn),
        .phase_b_low_request(pBL), .outputEnable(outputEnable), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .high_side_gate_out(highGate), .low_side_gate_out(lowGate), .topOffPumpOn(pump));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task drive(input logic [3:0] v);
        @(posedge sys_clk);
        cmd <= v;
    endtask : drive
    task axiWrite(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic awPend;
        logic wPend;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        awPend = 1'b1;
        wPend = 1'b1;
        while (awPend || wPend) begin
            @(posedge sys_clk);
            if (awPend && awready === 1'b1) begin
                awPend = 1'b0;
                awvalid <= 1'b0;
            end
            if (wPend && wready === 1'b1) begin
                wPend = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge sys_clk);
        resp = bresp;
        bready <= 1'b0;
    endtask : axiWrite
    task axiRead(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge sys_clk);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axiRead
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #3_000_000;
        nErrors++;
        tally_and_finish();
    end
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int cnt;
        repeat (16) @(posedge sys_clk);
        nrst <= 1'b1;
        step(1);
        check("gates after reset", gates, 0);
        check("pumps after reset", pump, 0);
        axiRead(bridge_pkg::ADDR_CONTROL, d, r);
        check("control reset", d, bridge_pkg::CTRL_RESET);
        axiRead(bridge_pkg::ADDR_DEADTIME, d, r);
        check("dead time reset", d, bridge_pkg::DT_RESET);
        axiRead(12'h00C, d, r);
        check("unmapped read data", d, 0);
        check("unmapped read resp", r, bridge_pkg::RESP_SLVERR);
        axiWrite(12'h00C, 32'h0000_000F, r);
        check("unmapped write resp", r, bridge_pkg::RESP_SLVERR);
        $display("test reset and map done");
        for (int i = 0; i < 4; i++) begin
            drive(4'h1 << i);
            step(3);
            check("pin gates", gates, 4'h1 << i);
            check("pin pumps", pump, {cmd[2], cmd[0]});
        end
        drive(4'h0);
        for (int i = 0; i < 4; i++) begin
            axiWrite(bridge_pkg::ADDR_CONTROL, 32'h1 << i, r);
            step(2);
            check("register gates", gates, 4'h1 << i);
        end
        $display("test single requests done");
        drive(4'h5);
        axiWrite(bridge_pkg::ADDR_CONTROL, 32'h0000_0002, r);
        step(2);
        check("lockout gates", gates, 4'h4);
        axiRead(bridge_pkg::ADDR_STATUS, d, r);
        check("lockout status", d, 32'h0000_0024);
        @(posedge sys_clk);
        outputEnable <= 1'b0;
        #1;
        check("disabled gates", gates, 0);
        check("disabled pumps", pump, 0);
        @(posedge sys_clk);
        outputEnable <= 1'b1;
        axiWrite(bridge_pkg::ADDR_CONTROL, 32'h0000_0000, r);
        $display("test lockout and disable done");
        foreach (codes[k]) begin
            axiWrite(bridge_pkg::ADDR_DEADTIME, codes[k], r);
            axiRead(bridge_pkg::ADDR_DEADTIME, d, r);
            check("dead time readback", d, codes[k]);
            drive(4'h0);
            step(40);
            drive(4'h1);
            step(3);
            drive(4'h2);
            cnt = 0;
            while (highGate[0] !== 1'b0 && cnt < 10) begin
                step(1);
                cnt++;
            end
            cnt = 0;
            while (lowGate[0] !== 1'b1 && cnt < 100) begin
                step(1);
                cnt++;
            end
            check("gap cycles", cnt, codes[k] == 0 ? 0 : ((codes[k] < 2 ? 2 : codes[k]) + 1) / 2);
        end
        drive(4'h0);
        step(40);
        drive(4'h1);
        step(2);
        check("undelayed turn on", gates, 4'h1);
        $display("test dead time done");
        tally_and_finish();
    end
endmodule : tb_bridge_gate_ctrl
`default_nettype wire
